/* File: verilog/dss_defines.svh */
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// register byte offsets
`define DSS_CTRL_OFFSET       8'h00
`define DSS_STATUS_OFFSET     8'h04

// control register fields
`define DSS_CTRL_SWITCH_ON    0
`define DSS_CTRL_RAMP_STOP    1
`define DSS_CTRL_COAST_STOP   2
`define DSS_CTRL_QUICK_STOP   3
`define DSS_CTRL_OP_ENABLE    4
`define DSS_CTRL_AUTO_START   5
`define DSS_CTRL_SRC_BUS      6
`define DSS_CTRL_DI_AUTO_EN   7
`define DSS_CTRL_WIDTH        8
`define DSS_CTRL_RESET        8'h80

// status register fields
`define DSS_STAT_STATE_LSB    0
`define DSS_STAT_STATE_MSB    2
`define DSS_STAT_MOTOR_ON     4
`define DSS_STAT_RAMP_BRAKE   5
`define DSS_STAT_QUICK_BRAKE  6
`define DSS_STAT_STANDSTILL   7

// cycles spent settling input synchronisers after reset
`define DSS_POWERUP_CYCLES    2'd3

// bus responses
`define DSS_RESP_OKAY         2'b00
`define DSS_RESP_SLVERR       2'b10

`endif

/* File: verilog/dss_pkg.sv */
`default_nettype none

package dss_pkg;

  typedef enum logic [2:0] {
    powerup_state             = 3'b000,
    switch_on_inhibited_state = 3'b001,
    ready_to_switch_on_state  = 3'b010,
    ready_state               = 3'b011,
    operation_state           = 3'b100,
    normal_stop_state         = 3'b101,
    fast_stop_state           = 3'b110
  } dss_state_t;

  typedef enum logic [1:0] {
    stop_none  = 2'b00,
    stop_ramp  = 2'b01,
    stop_quick = 2'b10,
    stop_coast = 2'b11
  } dss_stop_t;

endpackage : dss_pkg

`default_nettype wire

/* File: verilog/dss_sync.sv */
`default_nettype none

module dss_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  //////////////////////////////////////////////////////////////////////////
  // two flip-flops per bit, first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_reg;
      logic safe_reg;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_reg <= 1'b0;
          safe_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          safe_reg <= meta_reg;
        end
      end
      assign sync_out[i] = safe_reg;
    end
  endgenerate

endmodule : dss_sync

`default_nettype wire

/* File: verilog/dss_stop_arbiter.sv */
`default_nettype none

module dss_stop_arbiter (
  input  wire logic                ramp_stop,
  input  wire logic                quick_stop,
  input  wire logic                coast_stop,
  output wire dss_pkg::dss_stop_t  stop_sel
);

  //////////////////////////////////////////////////////////////////////////
  // coast beats quick, quick beats ramp
  assign stop_sel = coast_stop ? dss_pkg::stop_coast :
                    quick_stop ? dss_pkg::stop_quick :
                    ramp_stop  ? dss_pkg::stop_ramp  :
                                 dss_pkg::stop_none;

endmodule : dss_stop_arbiter

`default_nettype wire

/* File: verilog/dss_sequencer.sv */
// Implementation choices: the address map and the AXI4-Lite register port.
`include "dss_defines.svh"
`default_nettype none

// Summary of operation
// - after power-up wait ready to switch on
// - switch-on in ready leads to operation
// - ramp stop brakes, standstill returns ready to switch on
// - coast stop switches motor off at once
// - quick stop brakes fast, off at standstill
// - inhibited state ignores switch-on command
// - switch-on held at power-up inhibits start
// - automatic start skips the power-up inhibit
// - coast or quick stop enters inhibited
// - switch-on only via ready to switch on
// - ready state waits for operating enable
// - digital-input control enables operation automatically
// - operation state keeps motor-on asserted
module dss_sequencer #(
  parameter logic AUTO_START_DEFAULT = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        di_switch_on,
  input  wire logic        di_ramp_stop,
  input  wire logic        di_coast_stop,
  input  wire logic        di_quick_stop,
  input  wire logic        di_op_enable,
  input  wire logic        standstill_in,
  output logic [2:0]       state_out,
  output logic             motor_on,
  output logic             ramp_brake_req,
  output logic             quick_brake_req
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]          aw_addr_reg;
  logic                aw_got_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                w_got_reg;
  logic [`DSS_CTRL_WIDTH-1:0] ctrl_reg;
  logic [1:0]          pwr_cnt_reg;
  dss_pkg::dss_state_t state_reg;
  dss_pkg::dss_state_t state_next;
  logic [5:0]          pin_sync;
  dss_pkg::dss_stop_t  stop_sel;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs  = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire wr_go = aw_got_reg & w_got_reg & ~s_axi_bvalid;

  //////////////////////////////////////////////////////////////////////////
  // pin inputs through two flip-flops
  dss_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({standstill_in, di_op_enable, di_quick_stop,
                di_coast_stop, di_ramp_stop, di_switch_on}),
    .sync_out (pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // command source selection
  wire src_bus    = ctrl_reg[`DSS_CTRL_SRC_BUS];
  wire auto_start = ctrl_reg[`DSS_CTRL_AUTO_START];
  wire standstill = pin_sync[5];

  wire cmd_on    = src_bus ? ctrl_reg[`DSS_CTRL_SWITCH_ON]  : pin_sync[0];
  wire cmd_ramp  = src_bus ? ctrl_reg[`DSS_CTRL_RAMP_STOP]  : pin_sync[1];
  wire cmd_coast = src_bus ? ctrl_reg[`DSS_CTRL_COAST_STOP] : pin_sync[2];
  wire cmd_quick = src_bus ? ctrl_reg[`DSS_CTRL_QUICK_STOP] : pin_sync[3];

  // bus control takes enable from its control bit
  wire en_bus = ctrl_reg[`DSS_CTRL_OP_ENABLE];
  // digital-input control enables itself by default
  wire en_di  = ctrl_reg[`DSS_CTRL_DI_AUTO_EN] | pin_sync[4];
  wire op_en  = src_bus ? en_bus : en_di;

  dss_stop_arbiter u_arb (
    .ramp_stop  (cmd_ramp),
    .quick_stop (cmd_quick),
    .coast_stop (cmd_coast),
    .stop_sel   (stop_sel)
  );

  wire sel_coast = (stop_sel == dss_pkg::stop_coast);
  wire sel_quick = (stop_sel == dss_pkg::stop_quick);
  wire sel_ramp  = (stop_sel == dss_pkg::stop_ramp);
  wire any_stop  = (stop_sel != dss_pkg::stop_none);
  wire off_stop  = sel_coast | sel_quick;

  //////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dss_pkg::powerup_state: begin
        if (pwr_cnt_reg == `DSS_POWERUP_CYCLES) begin
          if (cmd_on & ~auto_start) begin
            state_next = dss_pkg::switch_on_inhibited_state;
          end else begin
            // automatic start lifts the inhibit
            state_next = dss_pkg::ready_to_switch_on_state;
          end
        end
      end
      dss_pkg::switch_on_inhibited_state: begin
        // switch-on is ignored; wait for it and the coast and quick stops to drop
        if (~cmd_on & ~off_stop) begin
          state_next = dss_pkg::ready_to_switch_on_state;
        end
      end
      dss_pkg::ready_to_switch_on_state: begin
        if (off_stop) begin
          state_next = dss_pkg::switch_on_inhibited_state;
        end else if (cmd_on & ~sel_ramp) begin
          state_next = dss_pkg::ready_state;
        end
      end
      dss_pkg::ready_state: begin
        if (off_stop) begin
          state_next = dss_pkg::switch_on_inhibited_state;
        end else if (~cmd_on | sel_ramp) begin
          state_next = dss_pkg::ready_to_switch_on_state;
        end else if (op_en) begin
          state_next = dss_pkg::operation_state;
        end
      end
      dss_pkg::operation_state: begin
        if (sel_coast) begin
          state_next = dss_pkg::switch_on_inhibited_state;
        end else if (sel_quick) begin
          state_next = dss_pkg::fast_stop_state;
        end else if (sel_ramp | ~cmd_on) begin
          state_next = dss_pkg::normal_stop_state;
        end else if (~op_en) begin
          state_next = dss_pkg::ready_state;
        end
      end
      dss_pkg::normal_stop_state: begin
        if (sel_coast) begin
          state_next = dss_pkg::switch_on_inhibited_state;
        end else if (sel_quick) begin
          state_next = dss_pkg::fast_stop_state;
        end else if (standstill) begin
          state_next = dss_pkg::ready_to_switch_on_state;
        end
      end
      dss_pkg::fast_stop_state: begin
        if (sel_coast | standstill) begin
          state_next = dss_pkg::switch_on_inhibited_state;
        end
      end
      default: begin
        state_next = dss_pkg::switch_on_inhibited_state;
      end
    endcase
  end

  wire next_run   = (state_next == dss_pkg::operation_state);
  wire next_ramp  = (state_next == dss_pkg::normal_stop_state);
  wire next_quick = (state_next == dss_pkg::fast_stop_state);

  //////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= dss_pkg::powerup_state;
      pwr_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (pwr_cnt_reg != `DSS_POWERUP_CYCLES) begin
        pwr_cnt_reg <= pwr_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_out       <= 3'h0;
      motor_on        <= 1'b0;
      ramp_brake_req  <= 1'b0;
      quick_brake_req <= 1'b0;
    end else begin
      state_out       <= state_next;
      // motor stays on while running or braking
      motor_on        <= next_run | next_ramp | next_quick;
      ramp_brake_req  <= next_ramp;
      quick_brake_req <= next_quick;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus write channel
  wire wr_ctrl = (aw_addr_reg == `DSS_CTRL_OFFSET);
  wire wr_stat = (aw_addr_reg == `DSS_STATUS_OFFSET);
  wire wr_ok   = wr_ctrl | wr_stat;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      aw_got_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready
                       & ~aw_got_reg & ~s_axi_bvalid;
      if (aw_hs) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_wready <= 1'b0;
      w_got_reg    <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
    end else begin
      s_axi_wready <= s_axi_wvalid & ~s_axi_wready
                      & ~w_got_reg & ~s_axi_bvalid;
      if (w_hs) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DSS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `DSS_RESP_OKAY : `DSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= `DSS_CTRL_RESET
                  | (8'(AUTO_START_DEFAULT) << `DSS_CTRL_AUTO_START);
    end else if (wr_go & wr_ctrl & w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[`DSS_CTRL_WIDTH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus read channel
  wire rd_ctrl = (s_axi_araddr == `DSS_CTRL_OFFSET);
  wire rd_stat = (s_axi_araddr == `DSS_STATUS_OFFSET);

  wire [31:0] stat_word = {24'h00_0000, standstill, quick_brake_req,
                           ramp_brake_req, motor_on, 1'b0, state_out};
  wire [31:0] ctrl_word = {24'h00_0000, ctrl_reg};
  wire [31:0] rd_word   = rd_ctrl ? ctrl_word :
                          rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DSS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_ctrl | rd_stat) ? `DSS_RESP_OKAY
                                            : `DSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : dss_sequencer

`default_nettype wire

/* File: dv/dss_seq_properties.sv */
`default_nettype none

module dss_seq_properties (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [2:0] state_out,
  input wire logic       motor_on,
  input wire logic       ramp_brake_req,
  input wire logic       quick_brake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MOTOR_ON: assert property (
    motor_on == (state_out inside {3'h4, 3'h5, 3'h6}))
    else $error("motor on does not match state");
  AST_RAMP_BRAKE: assert property (
    ramp_brake_req == (state_out == 3'h5))
    else $error("ramp brake does not match state");
  AST_QUICK_BRAKE: assert property (
    quick_brake_req == (state_out == 3'h6))
    else $error("quick brake does not match state");
  AST_RUN_FROM_READY: assert property (
    $past(resetn) && $changed(state_out) && state_out == 3'h4
    |-> $past(state_out) == 3'h3)
    else $error("operation entered from wrong state");
  AST_INHIBIT_HOLD: assert property (
    $past(resetn) && $past(state_out) == 3'h1
    |-> state_out inside {3'h1, 3'h2})
    else $error("inhibited state left wrongly");
  AST_POWERUP_EXIT: assert property (
    $past(resetn) && $past(state_out) == 3'h0 && state_out != 3'h0
    |-> state_out inside {3'h1, 3'h2})
    else $error("power-up left to wrong state");
  AST_NORMAL_EXIT: assert property (
    $past(resetn) && $past(state_out) == 3'h5
    |-> state_out inside {3'h5, 3'h6, 3'h1, 3'h2})
    else $error("normal stop left wrongly");
  AST_FAST_EXIT: assert property (
    $past(resetn) && $past(state_out) == 3'h6
    |-> state_out inside {3'h6, 3'h1})
    else $error("fast stop left wrongly");
  AST_POWERUP_LEN: assert property (
    $rose(resetn) |-> state_out == 3'h0 ##1 state_out == 3'h0
    ##[1:4] state_out inside {3'h1, 3'h2})
    else $error("power-up wait wrong length");
endmodule : dss_seq_properties

`default_nettype wire

/* File: dv/dss_motor_model.sv */
`default_nettype none

module dss_motor_model #(
  parameter int RAMP_CYC  = 20,
  parameter int QUICK_CYC = 10
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic motor_on,
  input  wire logic ramp_brake_req,
  input  wire logic quick_brake_req,
  output wire logic standstill_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // braking time counted from the request
  always @(posedge clk) begin
    if (!resetn || !(ramp_brake_req || quick_brake_req)) cnt <= 0;
    else cnt <= cnt + 1;
  end
  assign standstill_in = !motor_on
    || (ramp_brake_req && cnt >= RAMP_CYC)
    || (quick_brake_req && cnt >= QUICK_CYC);
endmodule : dss_motor_model

`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, exp, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rd, v;
  logic [1:0]       rr, br;
  logic [4:0]       di;
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic        stand, motor, rbrk, qbrk;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  st;
  int               miscompares, n_compared, seed;

  dss_sequencer dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .di_switch_on(di[4]),
    .di_ramp_stop(di[3]), .di_coast_stop(di[2]), .di_quick_stop(di[1]),
    .di_op_enable(di[0]), .standstill_in(stand), .state_out(st),
    .motor_on(motor), .ramp_brake_req(rbrk), .quick_brake_req(qbrk));
  dss_motor_model u_motor (.clk(clk), .resetn(resetn), .motor_on(motor),
    .ramp_brake_req(rbrk), .quick_brake_req(qbrk), .standstill_in(stand));

  //////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata; rr = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic go(input logic [7:0] c, input logic [2:0] s);
    axi_wr(8'h00, {24'h0, c});
    repeat (4) @(posedge clk);
    `CHK("state", s, st)
  endtask : go
  task automatic step(input logic [4:0] p, input logic [2:0] s);
    di <= p;
    repeat (6) @(posedge clk);
    `CHK("state", s, st)
  endtask : step
  task automatic brake_done(input logic [2:0] s);
    repeat (40) @(posedge clk);
    `CHK("state", s, st)
  endtask : brake_done
  task automatic stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  initial begin
    seed = 98096; resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h0;
    araddr = 8'h0; wdata = 32'h0; di = 5'b10000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("state", 3'h1, st)
    axi_rd(8'h00);
    `CHK("ctrl", 32'h80, rd)
    axi_rd(8'h40);
    `CHK("resp", 2'b10, rr)
    `CHK("rdata", 32'h0, rd)
    axi_wr(8'h40, 32'h0000_0001);
    `CHK("bresp", 2'b10, br)
    axi_rd(8'h00);
    `CHK("ctrl", 32'h80, rd)
    step(5'b10000, 3'h1);
    step(5'b00000, 3'h2);
    step(5'b10000, 3'h4);
    axi_rd(8'h04);
    `CHK("status", 32'h14, rd)
    step(5'b10100, 3'h1);
    `CHK("motor", 1'b0, motor)
    step(5'b00000, 3'h2);
    go(8'h40, 3'h2);
    go(8'h41, 3'h3);
    go(8'h51, 3'h4);
    go(8'h53, 3'h5);
    `CHK("ramp_brake", 1'b1, rbrk)
    brake_done(3'h2);
    go(8'h51, 3'h4);
    go(8'h5b, 3'h6);
    `CHK("quick_brake", 1'b1, qbrk)
    brake_done(3'h1);
    `CHK("motor", 1'b0, motor)
    go(8'h40, 3'h2);
    go(8'h51, 3'h4);
    go(8'h5f, 3'h1);
    // mid-run reset with switch-on held, automatic start set early
    di <= 5'b10000;
    resetn <= 1'b0;
    fork
      begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
      end
      begin
        repeat (2) @(posedge clk);
        axi_wr(8'h00, 32'h0000_00a0);
      end
    join
    repeat (6) @(posedge clk);
    `CHK("state", 3'h4, st)
    `CHK("motor", 1'b1, motor)
    repeat (40) begin
      v = $random(seed);
      di <= v[12:8];
      axi_wr(8'h00, v);
      axi_rd(8'h00);
      `CHK("ctrl", {24'h0, v[7:0]}, rd)
      `CHK("bresp", 2'b00, br)
      `CHK("rresp", 2'b00, rr)
    end
    stop_test;
  end
endmodule : testbench

bind dss_sequencer dss_seq_properties u_props (.clk(clk), .resetn(resetn),
  .state_out(state_out), .motor_on(motor_on),
  .ramp_brake_req(ramp_brake_req), .quick_brake_req(quick_brake_req));

`default_nettype wire
